// ---- src/dcb_pkg.sv ----
// package: offsets, fields, reset values and timing of the core control bits
package dcb_pkg;

	// register byte offsets
	localparam logic [6:0] CTRL_OFS = 7'h00;
	localparam logic [6:0] SLOT_ADDR_BASE = 7'h10;
	localparam logic [6:0] SLOT_DATA_BASE = 7'h30;

	// control register fields
	localparam int START_BIT = 0;
	localparam int ADC_MUTE_BIT = 1;
	localparam int DAC_MUTE_BIT = 2;
	localparam int CLEAR_BIT = 3;
	localparam int RATE_LSB = 4;
	localparam int PEND_LSB = 8;

	// reset values
	localparam logic CTRL_BIT_RST = 1'h0;
	localparam logic [1:0] RATE_RST = 2'h0;

	// safeload geometry
	localparam int SLOT_COUNT = 5;
	localparam int PRAM_AW = 10;
	localparam int PRAM_DW = 28;
	localparam logic [2:0] SLOT_LAST = 3'h4;

	// rate codes and instructions per sample
	localparam logic [1:0] RATE_1X = 2'h0;
	localparam logic [1:0] RATE_2X = 2'h1;
	localparam logic [1:0] RATE_4X = 2'h2;
	localparam logic [1:0] RATE_RSVD = 2'h3;
	localparam logic [10:0] INSTR_1X = 11'h400;
	localparam logic [10:0] INSTR_2X = 11'h200;
	localparam logic [10:0] INSTR_4X = 11'h100;

	typedef enum logic [1:0]
	{
		SL_IDLE = 2'b00,
		SL_WAIT = 2'b01,
		SL_COPY = 2'b10
	} dcb_sl_state_t;

	// instructions run per audio sample for a rate code
	function automatic logic [10:0] dcb_instr_count(input logic [1:0] rate);
		case (rate)
			RATE_2X: dcb_instr_count = INSTR_2X;
			RATE_4X: dcb_instr_count = INSTR_4X;
			default: dcb_instr_count = INSTR_1X;
		endcase
	endfunction

endpackage

// ---- src/dcb_frame_timer.sv ----
// audio frame timer: counts program instructions, pulses at each sample
module dcb_frame_timer
	import dcb_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// rate control
	input wire logic [1:0] rate_select_i,
	// frame boundary pulse
	output logic frame_o
);

	logic [10:0] instr_cnt;
	logic [10:0] limit;

	assign limit = dcb_instr_count(rate_select_i) - 11'h001;

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			instr_cnt <= 11'h000;
		else if (instr_cnt >= limit)
			instr_cnt <= 11'h000;
		else
			instr_cnt <= instr_cnt + 11'h001;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			frame_o <= 1'b0;
		else
			frame_o <= (instr_cnt >= limit);
	end

	// a frame pulse follows the last instruction of each sample
	property p_frame_len;
		@(posedge clk_i) disable iff (!reset_n_i)
		(instr_cnt == limit) |=> frame_o;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame pulse missing after last instruction");

	// quad rate gives a 256 instruction frame
	property p_quad_len;
		@(posedge clk_i) disable iff (!reset_n_i)
		(rate_select_i == RATE_4X && instr_cnt == 11'h0FF) |=> frame_o;
	endproperty
	a_quad_len: assert property (p_quad_len)
		else $error("quad rate frame is not 256 instructions");

endmodule

// ---- src/dcb_ctrl.sv ----
// control bits of the audio core with safeload transfer engine
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
module dcb_ctrl
	import dcb_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// avalon-mm slave
	input wire logic [6:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// core controls
	output logic adc_mute_n_o,
	output logic dac_mute_n_o,
	output logic core_clear_n_o,
	output logic [1:0] rate_select_o,
	output logic frame_o,
	// parameter ram write port
	output logic pram_we_o,
	output logic [PRAM_AW-1:0] pram_addr_o,
	output logic [PRAM_DW-1:0] pram_data_o
);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	logic safeload_start;
	logic [PRAM_AW-1:0] slot_addr [SLOT_COUNT];
	logic [PRAM_DW-1:0] slot_data [SLOT_COUNT];
	logic [SLOT_COUNT-1:0] pending;
	logic [SLOT_COUNT-1:0] addr_wr;
	logic [SLOT_COUNT-1:0] data_wr;
	logic [SLOT_COUNT-1:0] copy_clr;
	logic [2:0] slot_idx;
	dcb_sl_state_t sl_state;
	logic acc;
	logic wr_acc;
	logic ctrl_wr;
	logic start_wr;
	logic [31:0] ctrl_val;
	logic [31:0] rd_val;
	logic [31:0] wdata;

	// byte-enable merge of write data over the current value
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			be_merge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction

	// slot register decode, used for address and data banks
	function automatic logic slot_hit(input logic [6:0] addr,
		input logic [6:0] base, input int idx);
		slot_hit = (addr == base + 7'(4 * idx));
	endfunction

	// a request is served on the single cycle waitrequest is low
	assign acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
	assign wr_acc = acc && avs_write_i;
	assign ctrl_wr = wr_acc && (avs_address_i == CTRL_OFS);

	assign ctrl_val = {19'h00000, pending, 2'h0, rate_select_o,
		core_clear_n_o, dac_mute_n_o, adc_mute_n_o, safeload_start};
	assign wdata = be_merge(ctrl_val, avs_writedata_i, avs_byteenable_i);
	assign start_wr = ctrl_wr && wdata[START_BIT];

	always_comb
	begin
		rd_val = 32'h00000000;
		if (avs_address_i == CTRL_OFS)
			rd_val = ctrl_val;
		else
		begin
			for (int i = 0; i < SLOT_COUNT; i++)
			begin
				if (slot_hit(avs_address_i, SLOT_ADDR_BASE, i))
					rd_val = {22'h000000, slot_addr[i]};
				else if (slot_hit(avs_address_i, SLOT_DATA_BASE, i))
					rd_val = {4'h0, slot_data[i]};
			end
		end
	end

	// one wait cycle, then one ready cycle; unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			avs_waitrequest_o <= 1'b1;
		else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
			avs_waitrequest_o <= 1'b0;
		else
			avs_waitrequest_o <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_val;
	end

	// mute and clear bits all come up muted and cleared
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			adc_mute_n_o <= CTRL_BIT_RST;
			dac_mute_n_o <= CTRL_BIT_RST;
			core_clear_n_o <= CTRL_BIT_RST;
		end
		else if (ctrl_wr)
		begin
			adc_mute_n_o <= wdata[ADC_MUTE_BIT];
			dac_mute_n_o <= wdata[DAC_MUTE_BIT];
			core_clear_n_o <= wdata[CLEAR_BIT];
		end
	end

	// the reserved code is refused so the timer never sees it
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			rate_select_o <= RATE_RST;
		else if (ctrl_wr && wdata[RATE_LSB +: 2] != RATE_RSVD)
			rate_select_o <= wdata[RATE_LSB +: 2];
	end

	dcb_frame_timer dcb_frame_timer_inst
	(
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.rate_select_i(rate_select_o),
		.frame_o(frame_o)
	);

	// slot storage with a pending flag per pair
	genvar g;
	generate
		for (g = 0; g < SLOT_COUNT; g++)
		begin : gen_slot
			assign addr_wr[g] = wr_acc && slot_hit(avs_address_i,
				SLOT_ADDR_BASE, g);
			assign data_wr[g] = wr_acc && slot_hit(avs_address_i,
				SLOT_DATA_BASE, g);
			assign copy_clr[g] = (sl_state == SL_COPY) && (slot_idx == 3'(g));

			always_ff @(posedge clk_i)
			begin
				if (!reset_n_i)
					slot_addr[g] <= '0;
				else if (addr_wr[g])
					slot_addr[g] <= avs_writedata_i[PRAM_AW-1:0];
			end

			always_ff @(posedge clk_i)
			begin
				if (!reset_n_i)
					slot_data[g] <= '0;
				else if (data_wr[g])
					slot_data[g] <= avs_writedata_i[PRAM_DW-1:0];
			end

			// a fresh write wins over the clear of the copy
			always_ff @(posedge clk_i)
			begin
				if (!reset_n_i)
					pending[g] <= 1'b0;
				else if (addr_wr[g] || data_wr[g])
					pending[g] <= 1'b1;
				else if (copy_clr[g])
					pending[g] <= 1'b0;
			end
		end
	endgenerate

	// safeload sequencer: wait for a frame, then walk all five slots
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			sl_state <= SL_IDLE;
			slot_idx <= 3'h0;
		end
		else
		begin
			case (sl_state)
				SL_IDLE:
					if (safeload_start)
						sl_state <= SL_WAIT;
				SL_WAIT:
					if (frame_o)
					begin
						sl_state <= SL_COPY;
						slot_idx <= 3'h0;
					end
				SL_COPY:
					if (slot_idx == SLOT_LAST)
						sl_state <= SL_IDLE;
					else
						slot_idx <= slot_idx + 3'h1;
				default:
					sl_state <= SL_IDLE;
			endcase
		end
	end

	// a start written in the finishing cycle wins and reruns the copy
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			safeload_start <= 1'b0;
		else if (start_wr)
			safeload_start <= 1'b1;
		else if (sl_state == SL_COPY && slot_idx == SLOT_LAST)
			safeload_start <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			pram_we_o <= 1'b0;
			pram_addr_o <= '0;
			pram_data_o <= '0;
		end
		else
		begin
			pram_we_o <= (sl_state == SL_COPY) && pending[slot_idx];
			pram_addr_o <= slot_addr[slot_idx];
			pram_data_o <= slot_data[slot_idx];
		end
	end

	sequence s_copy_last;
		sl_state == SL_COPY && slot_idx == SLOT_LAST && !start_wr;
	endsequence
	sequence s_start_req;
		start_wr && sl_state == SL_IDLE;
	endsequence
	property p_start;
		s_start_req |=> safeload_start ##1 sl_state == SL_WAIT;
	endproperty
	a_start: assert property (p_start)
		else $error("safeload start did not arm the sequencer");
	property p_selfclear;
		s_copy_last |=> !safeload_start && sl_state == SL_IDLE;
	endproperty
	a_selfclear: assert property (p_selfclear)
		else $error("safeload start not cleared after copy");
	property p_skip;
		sl_state == SL_COPY && !pending[slot_idx] |=> !pram_we_o;
	endproperty
	a_skip: assert property (p_skip)
		else $error("untouched slot was copied");
	// the default disable would mask these, as they look at reset itself
	property p_adc_rst;
		@(posedge clk_i) disable iff (1'b0) !reset_n_i |=> !adc_mute_n_o;
	endproperty
	a_adc_rst: assert property (p_adc_rst)
		else $error("adc mute not active after reset");
	property p_dac_rst;
		@(posedge clk_i) disable iff (1'b0) !reset_n_i |=> !dac_mute_n_o;
	endproperty
	a_dac_rst: assert property (p_dac_rst)
		else $error("dac mute not active after reset");
	property p_clear_wr;
		ctrl_wr |=> core_clear_n_o == $past(wdata[CLEAR_BIT]);
	endproperty
	a_clear_wr: assert property (p_clear_wr)
		else $error("core clear bit did not follow the write");
	property p_rate_rsvd;
		rate_select_o != RATE_RSVD;
	endproperty
	a_rate_rsvd: assert property (p_rate_rsvd)
		else $error("reserved rate code selected");
	property p_frame_copy;
		$rose(sl_state == SL_COPY) |-> $past(frame_o);
	endproperty
	a_frame_copy: assert property (p_frame_copy)
		else $error("safeload copy began off a frame boundary");

endmodule

// ---- tb/tb.sv ----
// self-checking bench for the core control bits block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dcb_pkg::*;

	// clock and reset
	logic clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	// avalon-mm master side
	logic [6:0] avs_address_i = 7'h00;
	logic avs_read_i = 1'h0;
	logic avs_write_i = 1'h0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	// core controls and parameter ram port
	logic adc_mute_n_o;
	logic dac_mute_n_o;
	logic core_clear_n_o;
	logic [1:0] rate_select_o;
	logic frame_o;
	logic pram_we_o;
	logic [PRAM_AW-1:0] pram_addr_o;
	logic [PRAM_DW-1:0] pram_data_o;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;

	dcb_ctrl dcb_ctrl_inst (
		.clk_i(clk_i), .reset_n_i(reset_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.adc_mute_n_o(adc_mute_n_o), .dac_mute_n_o(dac_mute_n_o),
		.core_clear_n_o(core_clear_n_o), .rate_select_o(rate_select_o),
		.frame_o(frame_o), .pram_we_o(pram_we_o),
		.pram_addr_o(pram_addr_o), .pram_data_o(pram_data_o)
	);

	always #50 clk_i = ~clk_i;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// worst case is a few frames of 1024 cycles per scenario
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one avalon access; called just after a rising edge
	task automatic bus(input logic wr, input logic [6:0] a,
		input logic [31:0] d, output logic [31:0] q);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge clk_i);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic t_reset();
		logic [31:0] q;
		chk({adc_mute_n_o, dac_mute_n_o, core_clear_n_o}, 32'h0);
		chk(rate_select_o, RATE_RST);
		bus(1'b0, CTRL_OFS, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, 7'h7C, 32'h0, q);
		chk(q, 32'h0);
	endtask

	task automatic t_bits();
		logic [31:0] q;
		bus(1'b1, CTRL_OFS, 32'h0000000A, q);
		chk({adc_mute_n_o, dac_mute_n_o, core_clear_n_o}, 32'h5);
		bus(1'b1, CTRL_OFS, 32'h0000000E, q);
		chk({adc_mute_n_o, dac_mute_n_o, core_clear_n_o}, 32'h7);
		bus(1'b0, CTRL_OFS, 32'h0, q);
		chk(q, 32'h0000000E);
	endtask

	// measures whole frame periods for each legal rate code
	task automatic t_rate();
		logic [31:0] q;
		logic [10:0] exp [3] = '{INSTR_1X, INSTR_2X, INSTR_4X};
		int n;
		for (int r = 0; r < 3; r++)
		begin
			bus(1'b1, CTRL_OFS, 32'h0E | (r << RATE_LSB), q);
			chk(rate_select_o, r);
			repeat (2)
				@(posedge clk_i iff frame_o === 1'b1);
			n = 0;
			do
			begin
				@(posedge clk_i);
				n++;
			end while (frame_o !== 1'b1 && n < 2000);
			chk(n, exp[r]);
		end
		// reserved code must leave the rate unchanged
		bus(1'b1, CTRL_OFS, 32'h3E, q);
		bus(1'b0, CTRL_OFS, 32'h0, q);
		chk(q[5:4], RATE_4X);
	endtask

	task automatic t_safeload();
		logic [31:0] q;
		logic [37:0] exp [$];
		logic seen_frame;
		int wr;
		bus(1'b1, SLOT_ADDR_BASE + 7'h04, 32'h155, q);
		bus(1'b1, SLOT_DATA_BASE + 7'h04, 32'h0ABCDEF0, q);
		bus(1'b1, SLOT_DATA_BASE + 7'h0C, 32'h01234567, q);
		bus(1'b1, SLOT_ADDR_BASE + 7'h0C, 32'h2AA, q);
		exp = '{{10'h155, 28'hABCDEF0}, {10'h2AA, 28'h1234567}};
		bus(1'b0, CTRL_OFS, 32'h0, q);
		chk(q[12:8], 32'h0A);
		bus(1'b1, CTRL_OFS, 32'h2F, q);
		seen_frame = 1'b0;
		wr = 0;
		// a pending slot may land only after a frame boundary
		repeat (600)
		begin
			@(posedge clk_i);
			if (pram_we_o === 1'b1)
			begin
				chk(seen_frame, 1'b1);
				if (wr < 2)
					chk({pram_addr_o, pram_data_o}, exp[wr]);
				wr++;
			end
			if (frame_o === 1'b1)
				seen_frame = 1'b1;
		end
		chk(wr, 2);
		bus(1'b0, CTRL_OFS, 32'h0, q);
		chk(q[0], 1'b0);
		chk(q[12:8], 32'h0);
	endtask

	initial
	begin
		repeat (20)
			@(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_bits();
		t_rate();
		t_safeload();
		wrap_up();
	end
endmodule
